// [shared/fct_pkg.sv]
// package: register map, field layout and carrier types of the channel A tap 3..7 coefficients
package fct_pkg;
   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_TAP3     = 12'h41c;
   localparam logic [11:0] IDX_TAP4     = 12'h41e;
   localparam logic [11:0] IDX_CENTRE   = 12'h420;
   localparam logic [11:0] IDX_TAP6     = 12'h423;
   localparam logic [11:0] IDX_TAP7     = 12'h425;
   localparam logic [11:0] IDX_CFG      = 12'h400;
   localparam logic [11:0] IDX_STATUS   = 12'h401;
   localparam int          BYTE_SHIFT   = 2;

   // storage widths and coefficient widths
   localparam int          SIDE_REG_W   = 16;
   localparam int          CTR_REG_W    = 24;
   localparam int          SIDE_W       = 12;
   localparam int          CTR_W        = 18;
   localparam int          SCW_W        = 3;
   localparam int          SCALED_W     = 18;

   // configuration register fields
   localparam int          CFG_MODE_LSB  = 0;
   localparam int          CFG_SCW_LSB   = 2;
   localparam int          CFG_MERGE_BIT = 5;
   localparam int          CFG_W         = 6;

   // status register fields
   localparam int          ST_ACTIVE_BIT = 0;
   localparam int          ST_MERGED_BIT = 1;
   localparam int          ST_BADCFG_BIT = 2;
   localparam int          ST_LINK_BIT   = 3;

   // mode encodings and legal side weight limit
   localparam logic [1:0]  MODE_BYPASS  = 2'h0;
   localparam logic [1:0]  MODE_ACTIVE  = 2'h2;
   localparam logic [2:0]  SCW_MAX      = 3'h6;

   // values after reset
   localparam logic [SIDE_REG_W-1:0] SIDE_RESET = 16'h0000;
   localparam logic [CTR_REG_W-1:0]  CTR_RESET  = 24'h000000;
   localparam logic [CFG_W-1:0]      CFG_RESET  = 6'h00;

   typedef struct packed {
      logic                         active;
      logic                         merged;
      logic signed [SCALED_W-1:0]   tap3;
      logic signed [SCALED_W-1:0]   tap4;
      logic signed [CTR_W-1:0]      centre;
      logic signed [SCALED_W-1:0]   tap6;
      logic signed [SCALED_W-1:0]   tap7;
   } fct_coef_t;
endpackage

// [core/fct_coef_regs.sv]
// channel A coefficient registers for taps three to seven, with apb access and tap outputs
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps

// Contract
// - The third-tap register holds a 12-bit signed coefficient used as channel A tap three.
// - The fourth-tap register holds a 12-bit signed coefficient used as channel A tap four.
// - The centre tap is an 18-bit signed value in bits 17..0 of a 24-bit register.
// - The sixth-tap register holds a 12-bit signed coefficient used as channel A tap six.
// - The seventh-tap register holds a 12-bit signed coefficient used as channel A tap seven.
// - In single-channel operation the same registers in the same order feed the merged filter.
// - All coefficient registers reset to zero and their upper bits are writable and read back.
// - Mode 0 bypasses the filter, mode 2 enables it, and modes 1 and 3 are reserved.
// - The side weight field scales non-centre taps by an LSB weight of 2 to the field minus 16.
module fct_coef_regs (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [15:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   input  wire logic                 serial_link_enable,
   output fct_pkg::fct_coef_t        coef_out
);

   // =========================================================
   // helpers
   function automatic logic [15:0] word_addr(input logic [11:0] idx);
      word_addr = {2'h0, idx, 2'h0};
   endfunction

   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      lane_merge = res;
   endfunction

   function automatic logic signed [fct_pkg::SCALED_W-1:0] side_scale(
         input logic [fct_pkg::SIDE_REG_W-1:0] raw,
         input logic [fct_pkg::SCW_W-1:0]      scw);
      logic signed [fct_pkg::SCALED_W-1:0] ext;
      ext = fct_pkg::SCALED_W'($signed(raw[fct_pkg::SIDE_W-1:0]));
      side_scale = ext <<< scw;
   endfunction

   // =========================================================
   // decode helpers
   // true when the byte address points at the word of this index
   function automatic logic reg_hit(input logic [15:0] addr,
                                    input logic [11:0] idx);
      reg_hit = (addr == word_addr(idx));
   endfunction

   // status word: read only, writes to it are dropped
   function automatic logic [31:0] status_word(input logic [1:0] mode,
                                               input logic       merge,
                                               input logic       bad,
                                               input logic       link);
      logic [31:0] res;
      res                         = 32'h0000_0000;
      res[fct_pkg::ST_ACTIVE_BIT] = (mode == fct_pkg::MODE_ACTIVE);
      res[fct_pkg::ST_MERGED_BIT] = merge;
      res[fct_pkg::ST_BADCFG_BIT] = bad;
      res[fct_pkg::ST_LINK_BIT]   = link;
      status_word = res;
   endfunction

   // reserved mode codes and weights past the legal limit
   function automatic logic cfg_illegal(input logic [1:0]                mode,
                                        input logic [fct_pkg::SCW_W-1:0] scw);
      cfg_illegal = (mode != fct_pkg::MODE_BYPASS && mode != fct_pkg::MODE_ACTIVE) ||
                    (scw > fct_pkg::SCW_MAX);
   endfunction

   // =========================================================
   // link enable synchroniser
   // only the second stage feeds logic; the first may be metastable
   logic link_meta_r;
   logic link_meta_nxt;
   logic link_sync_r;
   logic link_sync_nxt;

   always_comb begin
      link_meta_nxt = serial_link_enable;
      link_sync_nxt = link_meta_r;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link_meta_r <= 1'b0;
         link_sync_r <= 1'b0;
      end else begin
         link_meta_r <= link_meta_nxt;
         link_sync_r <= link_sync_nxt;
      end
   end

   // =========================================================
   // register file storage and bus answer
   logic [fct_pkg::SIDE_REG_W-1:0] tap3_coef_r;
   logic [fct_pkg::SIDE_REG_W-1:0] tap3_coef_nxt;
   logic [fct_pkg::SIDE_REG_W-1:0] tap4_coef_r;
   logic [fct_pkg::SIDE_REG_W-1:0] tap4_coef_nxt;
   logic [fct_pkg::CTR_REG_W-1:0]  centre_tap_coef_r;
   logic [fct_pkg::CTR_REG_W-1:0]  centre_tap_coef_nxt;
   logic [fct_pkg::SIDE_REG_W-1:0] tap6_coef_r;
   logic [fct_pkg::SIDE_REG_W-1:0] tap6_coef_nxt;
   logic [fct_pkg::SIDE_REG_W-1:0] tap7_coef_r;
   logic [fct_pkg::SIDE_REG_W-1:0] tap7_coef_nxt;
   logic [fct_pkg::CFG_W-1:0]      cfg_r;
   logic [fct_pkg::CFG_W-1:0]      cfg_nxt;
   logic                           pready_r;
   logic                           pready_nxt;
   logic [31:0]                    prdata_r;
   logic [31:0]                    prdata_nxt;
   logic                           pslverr_r;
   logic                           pslverr_nxt;

   logic [1:0]                     equalizer_mode;
   logic [fct_pkg::SCW_W-1:0]      side_coef_weight;
   logic                           filter_merge;
   logic                           bad_cfg;
   logic                           setup;
   logic                           wr_now;
   logic                           hit;
   logic [31:0]                    cur;
   logic [31:0]                    wv;
   logic                           sel_tap3;
   logic                           sel_tap4;
   logic                           sel_centre;
   logic                           sel_tap6;
   logic                           sel_tap7;
   logic                           sel_cfg;
   logic                           sel_status;
   logic                           wr_tap3;
   logic                           wr_tap4;
   logic                           wr_centre;
   logic                           wr_tap6;
   logic                           wr_tap7;
   logic                           wr_cfg;

   assign equalizer_mode   = cfg_r[fct_pkg::CFG_MODE_LSB +: 2];
   assign side_coef_weight = cfg_r[fct_pkg::CFG_SCW_LSB +: fct_pkg::SCW_W];
   assign filter_merge     = cfg_r[fct_pkg::CFG_MERGE_BIT];
   assign bad_cfg          = cfg_illegal(equalizer_mode, side_coef_weight);
   assign setup            = psel && !penable;
   // write only in an answered access, never on a refused address
   assign wr_now           = psel && penable && pwrite && pready_r && !pslverr_r;

   // =========================================================
   // address decode, one select per word
   assign sel_tap3   = reg_hit(paddr, fct_pkg::IDX_TAP3);
   assign sel_tap4   = reg_hit(paddr, fct_pkg::IDX_TAP4);
   assign sel_centre = reg_hit(paddr, fct_pkg::IDX_CENTRE);
   assign sel_tap6   = reg_hit(paddr, fct_pkg::IDX_TAP6);
   assign sel_tap7   = reg_hit(paddr, fct_pkg::IDX_TAP7);
   assign sel_cfg    = reg_hit(paddr, fct_pkg::IDX_CFG);
   assign sel_status = reg_hit(paddr, fct_pkg::IDX_STATUS);
   assign hit        = sel_tap3 || sel_tap4 || sel_centre || sel_tap6 || sel_tap7 ||
                       sel_cfg || sel_status;

   assign wr_tap3    = wr_now && sel_tap3;
   assign wr_tap4    = wr_now && sel_tap4;
   assign wr_centre  = wr_now && sel_centre;
   assign wr_tap6    = wr_now && sel_tap6;
   assign wr_tap7    = wr_now && sel_tap7;
   assign wr_cfg     = wr_now && sel_cfg;

   // read mux of the word at paddr; upper storage bits read back as written
   always_comb begin
      cur = 32'h0000_0000;
      if (sel_tap3) begin
         cur[fct_pkg::SIDE_REG_W-1:0] = tap3_coef_r;
      end else if (sel_tap4) begin
         cur[fct_pkg::SIDE_REG_W-1:0] = tap4_coef_r;
      end else if (sel_centre) begin
         cur[fct_pkg::CTR_REG_W-1:0] = centre_tap_coef_r;
      end else if (sel_tap6) begin
         cur[fct_pkg::SIDE_REG_W-1:0] = tap6_coef_r;
      end else if (sel_tap7) begin
         cur[fct_pkg::SIDE_REG_W-1:0] = tap7_coef_r;
      end else if (sel_cfg) begin
         cur[fct_pkg::CFG_W-1:0] = cfg_r;
      end else if (sel_status) begin
         cur = status_word(equalizer_mode, filter_merge, bad_cfg, link_sync_r);
      end
   end

   // byte lanes merged over the current word before storage
   assign wv = lane_merge(cur, pwdata, pstrb);

   // =========================================================
   // coefficient storage; whole storage word writable at the access edge
   // taken at once even with the link running; software keeps the link off
   always_comb begin
      tap3_coef_nxt       = tap3_coef_r;
      tap4_coef_nxt       = tap4_coef_r;
      centre_tap_coef_nxt = centre_tap_coef_r;
      tap6_coef_nxt       = tap6_coef_r;
      tap7_coef_nxt       = tap7_coef_r;
      if (wr_tap3) begin
         tap3_coef_nxt = wv[fct_pkg::SIDE_REG_W-1:0];
      end
      if (wr_tap4) begin
         tap4_coef_nxt = wv[fct_pkg::SIDE_REG_W-1:0];
      end
      if (wr_centre) begin
         centre_tap_coef_nxt = wv[fct_pkg::CTR_REG_W-1:0];
      end
      if (wr_tap6) begin
         tap6_coef_nxt = wv[fct_pkg::SIDE_REG_W-1:0];
      end
      if (wr_tap7) begin
         tap7_coef_nxt = wv[fct_pkg::SIDE_REG_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tap3_coef_r       <= fct_pkg::SIDE_RESET;
         tap4_coef_r       <= fct_pkg::SIDE_RESET;
         centre_tap_coef_r <= fct_pkg::CTR_RESET;
         tap6_coef_r       <= fct_pkg::SIDE_RESET;
         tap7_coef_r       <= fct_pkg::SIDE_RESET;
      end else begin
         tap3_coef_r       <= tap3_coef_nxt;
         tap4_coef_r       <= tap4_coef_nxt;
         centre_tap_coef_r <= centre_tap_coef_nxt;
         tap6_coef_r       <= tap6_coef_nxt;
         tap7_coef_r       <= tap7_coef_nxt;
      end
   end

   // =========================================================
   // configuration word; reserved codes are stored and flagged, not refused
   // side weight above the legal limit is kept as written, not clamped
   always_comb begin
      cfg_nxt = cfg_r;
      if (wr_cfg) begin
         cfg_nxt = wv[fct_pkg::CFG_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= fct_pkg::CFG_RESET;
      end else begin
         cfg_r <= cfg_nxt;
      end
   end

   // =========================================================
   // bus answer: one access cycle, prepared in setup, shown during access
   // a write answer carries zero read data
   always_comb begin
      pready_nxt  = setup;
      pslverr_nxt = setup && !hit;
      prdata_nxt  = (setup && !pwrite) ? cur : 32'h0000_0000;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= pready_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign pready  = pready_r;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   // =========================================================
   // coefficient outputs to the tap multipliers
   fct_pkg::fct_coef_t coef_r, coef_nxt;

   always_comb begin
      coef_nxt        = '0;
      // reserved modes are treated as bypass
      coef_nxt.active = (equalizer_mode == fct_pkg::MODE_ACTIVE);
      // same registers and tap order serve the merged single filter
      coef_nxt.merged = filter_merge;
      coef_nxt.tap3   = side_scale(tap3_coef_r, side_coef_weight);
      coef_nxt.tap4   = side_scale(tap4_coef_r, side_coef_weight);
      coef_nxt.centre = centre_tap_coef_r[fct_pkg::CTR_W-1:0];
      coef_nxt.tap6   = side_scale(tap6_coef_r, side_coef_weight);
      coef_nxt.tap7   = side_scale(tap7_coef_r, side_coef_weight);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         coef_r <= '0;
      end else begin
         coef_r <= coef_nxt;
      end
   end

   assign coef_out = coef_r;

endmodule // fct_coef_regs

// [tb/fct_coef_regs_props.sv]
// checker: apb timing, decode and coefficient output properties
`timescale 1ns/1ps
module fct_coef_regs_props (
   input wire logic               clk,
   input wire logic               rst_b,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [15:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         pstrb,
   input wire logic               pready,
   input wire logic [31:0]        prdata,
   input wire logic               pslverr,
   input wire logic               serial_link_enable,
   input wire fct_pkg::fct_coef_t coef_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic mapped;
   assign mapped = paddr inside {16'h1070, 16'h1078, 16'h1080, 16'h108c, 16'h1094,
                                 16'h1000, 16'h1004};
   // ==========
   // full-word write accepted
   sequence wr_done(a);
      psel && penable && pready && pwrite && paddr == a && pstrb == 4'hf;
   endsequence
   property ctr_follow;
      wr_done(16'h1080) |-> ##2 coef_out.centre == $past(pwdata[17:0], 2);
   endproperty
   property mode_follow;
      wr_done(16'h1000) |-> ##2 coef_out.active == ($past(pwdata[1:0], 2) == 2'h2);
   endproperty
   property merge_follow;
      wr_done(16'h1000) |-> ##2 coef_out.merged == $past(pwdata[5], 2);
   endproperty
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_ready_one_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_err_on_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("wrong decode error");
   a_centre_follows: assert property (ctr_follow)
      else $error("centre tap not applied");
   a_mode_sets_active: assert property (mode_follow)
      else $error("active does not follow mode");
   a_merge_follows: assert property (merge_follow)
      else $error("merged does not follow merge");
endmodule // fct_coef_regs_props

bind fct_coef_regs fct_coef_regs_props u_props (.clk(clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .serial_link_enable(serial_link_enable), .coef_out(coef_out));

// [tb/test_fct_coef_regs.sv]
// testbench: apb access and coefficient outputs of the tap 3..7 block
`timescale 1ns/1ps
module test_fct_coef_regs;
   logic               clk, rst_b, psel, penable, pwrite, link, pready, pslverr, er;
   logic [15:0]        paddr;
   logic [15:0]        adr[5];
   logic [31:0]        pwdata, prdata, rd;
   logic [31:0]        v[5];
   logic [3:0]         pstrb;
   fct_pkg::fct_coef_t coef_out;
   int                 num_errors, n_checks;
   fct_coef_regs uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .serial_link_enable(link), .coef_out(coef_out));
   // ==========
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [17:0] exp_tap(input logic [11:0] r, input int s);
      logic [17:0] x;
      x = {{6{r[11]}}, r};
      return x << s;
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #400000;
      num_errors++;
      test_done();
   end
   // ==========
   // main sequence
   initial begin
      adr = '{16'h1070, 16'h1078, 16'h1080, 16'h108c, 16'h1094};
      {rst_b, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      link = 1'b0;
      void'($urandom(32'h8683));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, adr[i], 32'h0, 4'h0);
         chk(rd, 32'h0);
      end
      for (int s = 0; s < 7; s++) begin
         apb(1'b1, 16'h1000, 32'((s << 2) | ((s & 1) << 5) | 2), 4'hf);
         for (int i = 0; i < 5; i++) begin
            v[i] = (s == 0) ? 32'hfffff800 : $urandom;
            apb(1'b1, adr[i], v[i], 4'hf);
            apb(1'b0, adr[i], 32'h0, 4'h0);
            chk(rd, v[i] & ((i == 2) ? 32'hffffff : 32'hffff));
         end
         repeat (2) @(posedge clk);
         chk({coef_out.tap3}, exp_tap(v[0][11:0], s));
         chk({coef_out.tap4}, exp_tap(v[1][11:0], s));
         chk({coef_out.centre}, v[2][17:0]);
         chk({coef_out.tap6}, exp_tap(v[3][11:0], s));
         chk({coef_out.tap7}, exp_tap(v[4][11:0], s));
         chk({coef_out.active, coef_out.merged}, {1'b1, s[0]});
      end
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 16'h1000, 32'(m), 4'hf);
         repeat (2) @(posedge clk);
         chk({coef_out.active}, 32'(m == 2));
         apb(1'b0, 16'h1004, 32'h0, 4'h0);
         chk(rd, 32'({m[0], 1'b0, m == 2}));
      end
      apb(1'b1, 16'h1010, 32'hffffffff, 4'hf);
      chk({er}, 32'h1);
      apb(1'b0, 16'h1010, 32'h0, 4'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, adr[0], 32'h0, 4'hf);
      apb(1'b1, adr[0], 32'hffffffff, 4'h1);
      apb(1'b0, adr[0], 32'h0, 4'h0);
      chk(rd, 32'h00ff);
      apb(1'b1, 16'h1000, 32'h3c, 4'hf);
      apb(1'b0, 16'h1004, 32'h0, 4'h0);
      chk(rd, 32'h6);
      link <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, 16'h1004, 32'h0, 4'h0);
      chk({rd[3]}, 32'h1);
      test_done();
   end
endmodule // test_fct_coef_regs
